// ==== common/sqci_pkg.sv ====
// constants and types for the monitor timeout, s/q channel and c/i channel block
// assumes a 64-bit highway frame with one 32-bit slot per channel group
package sqci_pkg;
    localparam logic [5:0] LAST_BIT = 6'h3f;
    localparam int MON_POS = 16;
    localparam int CI0_POS = 26;
    localparam int MR_POS = 30;
    localparam int MX_POS = 31;
    localparam int CI1_POS = 56;
    localparam int MF_FRAMES = 20;
    localparam logic [4:0] CMD_OPEN_LAST = 5'h11;
    localparam logic [4:0] SF_FIRST = 5'h01;
    localparam logic [3:0] TYPE_S1Q = 4'h1;
    localparam logic [3:0] TYPE_S2 = 4'h2;
    localparam logic [1:0] EOM_FRAMES = 2'h2;
    localparam logic [1:0] IDLE_FRAMES = 2'h2;
    localparam logic [1:0] MODE_SUBSCRIBER = 2'h0;
    localparam logic [1:0] MODE_TRUNK = 2'h1;
    localparam logic [1:0] MODE_LINE_CARD = 2'h2;
    localparam logic [2:0] ADDR_CONFIG = 3'h0;
    localparam logic [2:0] ADDR_L1_TX = 3'h1;
    localparam logic [2:0] ADDR_L1_RX = 3'h2;
    localparam logic [2:0] ADDR_P_TX = 3'h3;
    localparam logic [2:0] ADDR_P_RX = 3'h4;
    localparam logic [2:0] ADDR_STATUS = 3'h5;
    localparam int CFG_TOD = 0;
    localparam int CFG_MFD = 1;
    localparam int CFG_SQM = 2;
    localparam int CFG_MODE = 3;
    localparam int ST_CI0 = 0;
    localparam int ST_CI1 = 1;
    localparam int ST_LOCK = 2;
    localparam logic [3:0] CI0_RST = 4'hf;
    localparam logic [5:0] CI1_RST = 6'h3f;
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_EOM} sqci_tx_e;
endpackage

// ==== design/sqci_top.sv ====
// monitor lock-up timeout, one-byte s1/q and s2 channel exchange and c/i channels
// assumes hw_clk/hw_sync/hw_up_data are asynchronous highway pins, s_* from same clock
//
// Behaviour
// [R01] timeout runs only when disable bit clear
// [R02] check once per multiframe at frame 20
// [R03] unchanged active status across checks is lock-up
// [R04] lock-up: two frames transmit high, then resend
// [R05] multiframe disable stops pulses and messages
// [R06] commands accepted only while s-interface active
// [R07] one-byte receive latch held until read
// [R08] controller reads each message per multiframe
// [R09] frames 1-17: first command acked, rest refused
// [R10] frames 18-20: command overwrites transmit register
// [R11] controller sends one command per channel
// [R12] separate s1 and s2 transmit registers
// [R13] stored command goes out next multiframe
// [R14] s1/q message sent before s2 message
// [R15] mode bit selects transparent or non-auto
// [R16] non-auto mode ignores s2 commands
// [R17] non-auto reports only changed s1/q data
// [R18] transparent forwards every multiframe, no compare; code does not latch s2 data in line card mode
// [R19] upper nibble type code, lower nibble data
// [R20] four-bit layer-1 code, sent every frame
// [R21] layer-1 code needs two equal frames
// [R22] peripheral channel only subscriber mode, no filter
// [R23] idle check discards stored status
// [R24] idle after mr and mx high two frames
`timescale 1ns/1ps
module sqci_top #(
    parameter int MF_LEN = sqci_pkg::MF_FRAMES
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic hw_clk,
    input wire logic hw_sync,
    input wire logic hw_up_data,
    output logic hw_down_data,
    input wire logic s_active,
    input wire logic s_mf_pulse,
    input wire logic s_frame_pulse,
    input wire logic s_rx_valid,
    input wire logic [3:0] s_rx_s1q,
    input wire logic [3:0] s_rx_s2,
    output logic [3:0] s_tx_s1q,
    output logic [3:0] s_tx_s2,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata
);
    if (MF_LEN < 18 || MF_LEN > 31)
    begin : g_chk
        $error("MF_LEN must lie between 18 and 31");
    end

    localparam logic [4:0] MF_LAST = 5'(MF_LEN);

    typedef struct packed {
        logic [2:0] clk_sr;
        logic [1:0] sync_sr;
        logic [1:0] up_sr;
        logic [5:0] bit_cnt;
        logic [63:0] rx_w;
        logic [63:0] tx_w;
        logic dd;
        logic timeout_disable_bit;
        logic multiframe_disable_bit;
        logic sq_transparent_select;
        logic [1:0] mode;
        logic [3:0] ci0_tx;
        logic [3:0] ci0_prev;
        logic [3:0] ci0_reg;
        logic [5:0] ci1_tx;
        logic [5:0] ci1_reg;
        logic st_ci0;
        logic st_ci1;
        logic st_lock;
        logic [4:0] sf_num;
        logic [3:0] s1_buf;
        logic [3:0] s2_buf;
        logic s1_loaded;
        logic s2_loaded;
        logic [3:0] tx_s1q;
        logic [3:0] tx_s2;
        logic [3:0] lat1;
        logic [3:0] lat2;
        logic [3:0] last1;
        logic lat1_full;
        logic lat2_full;
        logic [7:0] mon_prev;
        logic mon_prev_ok;
        logic mon_done;
        logic mr_out;
        logic [1:0] idle_cnt;
        sqci_pkg::sqci_tx_e txs;
        logic [7:0] tx_byte;
        logic tx_is_s2;
        logic [1:0] eom_cnt;
        logic saved_ok;
        logic [9:0] saved;
        logic [7:0] rdata;
    } sqci_state_s;

    sqci_state_s s;
    sqci_state_s n;
    logic rise;
    logic done;
    logic [5:0] idx;
    logic [63:0] rxw;
    logic [7:0] cmd;
    logic late;
    logic mf_go;
    logic sf_go;
    logic check;
    logic active;
    logic lock_hit;
    logic [9:0] snap;
    logic set_ci0;
    logic set_ci1;
    logic [2:0] clr;

    // monitor byte travels msb first from the lowest bit position
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    always_comb
    begin
        n = s;
        n.clk_sr = {s.clk_sr[1:0], hw_clk};
        n.sync_sr = {s.sync_sr[0], hw_sync};
        n.up_sr = {s.up_sr[0], hw_up_data};
        rise = s.clk_sr[1] & ~s.clk_sr[2];
        idx = s.sync_sr[1] ? 6'h00 : s.bit_cnt;
        done = rise && (idx == sqci_pkg::LAST_BIT);
        rxw = s.rx_w;
        rxw[idx] = s.up_sr[1];
        cmd = rev8(rxw[sqci_pkg::MON_POS +: 8]);
        late = s.sf_num > sqci_pkg::CMD_OPEN_LAST;
        // [R05] multiframe gating
        mf_go = s_mf_pulse && !s.multiframe_disable_bit;
        sf_go = s_frame_pulse && !s.multiframe_disable_bit;
        // [R01] [R02] check as the last s-frame starts; no pulse follows it before the next mf
        check = sf_go && !mf_go && (s.sf_num == MF_LAST - 5'h01) && !s.timeout_disable_bit;
        // [R24] idle detection
        active = (s.txs != sqci_pkg::TX_IDLE) || (s.idle_cnt != sqci_pkg::IDLE_FRAMES);
        snap = {s.txs, s.tx_byte};
        lock_hit = 1'b0;
        set_ci0 = 1'b0;
        set_ci1 = 1'b0;
        clr = 3'h0;

        if (rise)
        begin
            n.rx_w[idx] = s.up_sr[1];
            n.dd = s.tx_w[idx];
            n.bit_cnt = idx + 6'h01;
        end

        // [R13] new multiframe hands stored commands to the s side
        if (mf_go)
        begin
            n.sf_num = sqci_pkg::SF_FIRST;
            if (s.s1_loaded)
            begin
                n.tx_s1q = s.s1_buf;
            end
            if (s.s2_loaded)
            begin
                n.tx_s2 = s.s2_buf;
            end
            n.s1_loaded = 1'b0;
            n.s2_loaded = 1'b0;
        end
        else if (sf_go && s.sf_num != MF_LAST)
        begin
            n.sf_num = s.sf_num + 5'h01;
        end

        // [R07] latch refills only once emptied by a read
        if (s_rx_valid && !s.multiframe_disable_bit)
        begin
            if (s.sq_transparent_select)
            begin
                // [R18] transparent forwarding
                if (!s.lat1_full)
                begin
                    n.lat1 = s_rx_s1q;
                    n.lat1_full = 1'b1;
                    n.last1 = s_rx_s1q;
                end
                if (!s.lat2_full && s.mode != sqci_pkg::MODE_LINE_CARD)
                begin
                    n.lat2 = s_rx_s2;
                    n.lat2_full = 1'b1;
                end
            end
            // [R17] change-only reporting
            else if (!s.lat1_full && s_rx_s1q != s.last1)
            begin
                n.lat1 = s_rx_s1q;
                n.lat1_full = 1'b1;
                n.last1 = s_rx_s1q;
            end
        end

        if (done)
        begin
            // [R21] double look on layer-1 code
            if (rxw[sqci_pkg::CI0_POS +: 4] == s.ci0_prev
                && rxw[sqci_pkg::CI0_POS +: 4] != s.ci0_reg)
            begin
                n.ci0_reg = rxw[sqci_pkg::CI0_POS +: 4];
                set_ci0 = 1'b1;
            end
            n.ci0_prev = rxw[sqci_pkg::CI0_POS +: 4];
            // [R22] peripheral code, any change flagged
            if (s.mode == sqci_pkg::MODE_SUBSCRIBER
                && rxw[sqci_pkg::CI1_POS +: 6] != s.ci1_reg)
            begin
                n.ci1_reg = rxw[sqci_pkg::CI1_POS +: 6];
                set_ci1 = 1'b1;
            end
            // [R24] idle count
            if (rxw[sqci_pkg::MR_POS] && rxw[sqci_pkg::MX_POS])
            begin
                if (s.idle_cnt != sqci_pkg::IDLE_FRAMES)
                begin
                    n.idle_cnt = s.idle_cnt + 2'h1;
                end
            end
            else
            begin
                n.idle_cnt = 2'h0;
            end

            // incoming command, taken once two equal frames were seen
            if (!rxw[sqci_pkg::MX_POS])
            begin
                if (s.mon_prev_ok && cmd == s.mon_prev && !s.mon_done)
                begin
                    n.mon_done = 1'b1;
                    // [R06] [R19] [R12] per-channel acceptance
                    if (s_active && cmd[7:4] == sqci_pkg::TYPE_S1Q)
                    begin
                        // [R09] [R10] window dependent acceptance
                        if (late || !s.s1_loaded)
                        begin
                            n.s1_buf = cmd[3:0];
                            n.s1_loaded = 1'b1;
                            n.mr_out = 1'b0;
                        end
                    end
                    // [R16] s2 only in transparent mode
                    else if (s_active && cmd[7:4] == sqci_pkg::TYPE_S2 && s.sq_transparent_select)
                    begin
                        if (late || !s.s2_loaded)
                        begin
                            n.s2_buf = cmd[3:0];
                            n.s2_loaded = 1'b1;
                            n.mr_out = 1'b0;
                        end
                    end
                end
            end
            else
            begin
                n.mon_done = 1'b0;
                n.mr_out = 1'b1;
            end
            n.mon_prev = cmd;
            n.mon_prev_ok = !rxw[sqci_pkg::MX_POS];

            case (s.txs)
                sqci_pkg::TX_IDLE:
                begin
                    // [R14] s1/q ahead of s2
                    if (s.lat1_full)
                    begin
                        n.tx_byte = {sqci_pkg::TYPE_S1Q, s.lat1};
                        n.tx_is_s2 = 1'b0;
                        n.txs = sqci_pkg::TX_SEND;
                    end
                    else if (s.lat2_full)
                    begin
                        n.tx_byte = {sqci_pkg::TYPE_S2, s.lat2};
                        n.tx_is_s2 = 1'b1;
                        n.txs = sqci_pkg::TX_SEND;
                    end
                end
                sqci_pkg::TX_SEND:
                begin
                    // [R07] read acknowledged, latch freed
                    if (!rxw[sqci_pkg::MR_POS])
                    begin
                        if (s.tx_is_s2)
                        begin
                            n.lat2_full = 1'b0;
                        end
                        else
                        begin
                            n.lat1_full = 1'b0;
                        end
                        n.txs = sqci_pkg::TX_EOM;
                        n.eom_cnt = 2'h0;
                    end
                end
                sqci_pkg::TX_EOM:
                begin
                    n.eom_cnt = s.eom_cnt + 2'h1;
                    if (s.eom_cnt == sqci_pkg::EOM_FRAMES - 2'h1)
                    begin
                        n.txs = sqci_pkg::TX_IDLE;
                    end
                end
                default:
                begin
                    n.txs = sqci_pkg::TX_IDLE;
                end
            endcase
        end

        // [R03] [R23] status compare across checks
        if (check)
        begin
            if (!active)
            begin
                n.saved_ok = 1'b0;
            end
            else if (s.saved_ok && snap == s.saved)
            begin
                // [R04] end of message, then the still-full latch is resent
                lock_hit = 1'b1;
                n.txs = sqci_pkg::TX_EOM;
                n.eom_cnt = 2'h0;
                n.saved_ok = 1'b0;
            end
            else
            begin
                n.saved = snap;
                n.saved_ok = 1'b1;
            end
        end

        // [R20] [R19] frame word built for the next frame
        if (done)
        begin
            n.tx_w = '1;
            n.tx_w[sqci_pkg::MON_POS +: 8] = rev8(n.tx_byte);
            n.tx_w[sqci_pkg::CI0_POS +: 4] = s.ci0_tx;
            n.tx_w[sqci_pkg::MR_POS] = n.mr_out;
            n.tx_w[sqci_pkg::MX_POS] = (n.txs != sqci_pkg::TX_SEND);
            if (s.mode == sqci_pkg::MODE_SUBSCRIBER)
            begin
                n.tx_w[sqci_pkg::CI1_POS +: 6] = s.ci1_tx;
            end
        end

        // [R15] configuration writes
        if (reg_wr)
        begin
            case (reg_addr)
                sqci_pkg::ADDR_CONFIG:
                begin
                    n.timeout_disable_bit = reg_wdata[sqci_pkg::CFG_TOD];
                    n.multiframe_disable_bit = reg_wdata[sqci_pkg::CFG_MFD];
                    n.sq_transparent_select = reg_wdata[sqci_pkg::CFG_SQM];
                    n.mode = reg_wdata[sqci_pkg::CFG_MODE +: 2];
                end
                sqci_pkg::ADDR_L1_TX: n.ci0_tx = reg_wdata[3:0];
                sqci_pkg::ADDR_P_TX: n.ci1_tx = reg_wdata[5:0];
                default: n.rdata = s.rdata;
            endcase
        end

        n.rdata = 8'h00;
        if (reg_rd)
        begin
            case (reg_addr)
                sqci_pkg::ADDR_CONFIG: n.rdata = {3'h0, s.mode, s.sq_transparent_select, s.multiframe_disable_bit, s.timeout_disable_bit};
                sqci_pkg::ADDR_L1_TX: n.rdata = {4'h0, s.ci0_tx};
                sqci_pkg::ADDR_L1_RX: n.rdata = {4'h0, s.ci0_reg};
                sqci_pkg::ADDR_P_TX: n.rdata = {2'h0, s.ci1_tx};
                sqci_pkg::ADDR_P_RX: n.rdata = {2'h0, s.ci1_reg};
                sqci_pkg::ADDR_STATUS:
                begin
                    n.rdata = {5'h00, s.st_lock, s.st_ci1, s.st_ci0};
                    clr = 3'h7;
                end
                default: n.rdata = 8'h00;
            endcase
        end
        // clear on read, a same-cycle event survives
        n.st_ci0 = (s.st_ci0 & ~clr[sqci_pkg::ST_CI0]) | set_ci0;
        n.st_ci1 = (s.st_ci1 & ~clr[sqci_pkg::ST_CI1]) | set_ci1;
        n.st_lock = (s.st_lock & ~clr[sqci_pkg::ST_LOCK]) | lock_hit;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s <= '0;
            s.tx_w <= '1;
            s.dd <= 1'b1;
            s.mr_out <= 1'b1;
            s.ci0_tx <= sqci_pkg::CI0_RST;
            s.ci0_prev <= sqci_pkg::CI0_RST;
            s.ci0_reg <= sqci_pkg::CI0_RST;
            s.ci1_tx <= sqci_pkg::CI1_RST;
            s.ci1_reg <= sqci_pkg::CI1_RST;
            s.sf_num <= sqci_pkg::SF_FIRST;
        end
        else
        begin
            s <= n;
        end
    end

    assign hw_down_data = s.dd;
    assign s_tx_s1q = s.tx_s1q;
    assign s_tx_s2 = s.tx_s2;
    assign reg_rdata = s.rdata;

    property p_tod_off;
        @(posedge clk) disable iff (sys_rst) s.timeout_disable_bit |=> !$rose(s.st_lock);
    endproperty
    a_tod_off: assert property (p_tod_off) else $error("lock-up with timeout off"); // [R01]

    property p_check_time;
        @(posedge clk) disable iff (sys_rst)
            lock_hit |-> (s_frame_pulse && !s_mf_pulse && s.sf_num == MF_LAST - 5'h01 && !s.multiframe_disable_bit);
    endproperty
    a_check_time: assert property (p_check_time) else $error("check off frame 20"); // [R02]

    property p_eom;
        @(posedge clk) disable iff (sys_rst)
            lock_hit |=> (s.txs == sqci_pkg::TX_EOM) && (s.eom_cnt == 2'h0) && s.st_lock;
    endproperty
    a_eom: assert property (p_eom) else $error("lock-up did not start end of message"); // [R04]

    property p_latch_hold;
        @(posedge clk) disable iff (sys_rst)
            (s.lat1_full && s.txs != sqci_pkg::TX_SEND) |=> s.lat1_full && $stable(s.lat1);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch reloaded unread"); // [R07]

    property p_refuse;
        @(posedge clk) disable iff (sys_rst)
            (s.s1_loaded && s.sf_num <= sqci_pkg::CMD_OPEN_LAST && !mf_go) |=> $stable(s.s1_buf);
    endproperty
    a_refuse: assert property (p_refuse) else $error("second s1 command taken early"); // [R09]

    property p_handoff;
        @(posedge clk) disable iff (sys_rst)
            (mf_go && s.s1_loaded) |=> (s_tx_s1q == $past(s.s1_buf)) && !s.s1_loaded [*1];
    endproperty
    a_handoff: assert property (p_handoff) else $error("stored s1 not handed over"); // [R13]

    property p_no_s2;
        @(posedge clk) disable iff (sys_rst) !s.sq_transparent_select |=> !$rose(s.s2_loaded);
    endproperty
    a_no_s2: assert property (p_no_s2) else $error("s2 taken in non-auto mode"); // [R16]

    property p_prio;
        @(posedge clk) disable iff (sys_rst)
            (done && s.txs == sqci_pkg::TX_IDLE && s.lat1_full && !check) |=> !s.tx_is_s2;
    endproperty
    a_prio: assert property (p_prio) else $error("s2 sent ahead of s1"); // [R14]

    property p_double_look;
        @(posedge clk) disable iff (sys_rst)
            $changed(s.ci0_reg) |-> $past(done && rxw[sqci_pkg::CI0_POS +: 4] == s.ci0_prev)
                && s.st_ci0;
    endproperty
    a_double_look: assert property (p_double_look) else $error("code taken on one look"); // [R21]

    property p_ci1_mode;
        @(posedge clk) disable iff (sys_rst)
            $changed(s.ci1_reg) |-> $past(s.mode == sqci_pkg::MODE_SUBSCRIBER) && s.st_ci1;
    endproperty
    a_ci1_mode: assert property (p_ci1_mode) else $error("peripheral code outside mode"); // [R22]
endmodule

// ==== verification/sqci_hw_model.sv ====
// highway controller model: makes bit clock and frame sync, shifts one word up, captures down
// assumes the device samples upstream bits on a rising hw_clk and drives downstream after it
`timescale 1ns/1ps
module sqci_hw_model (
    output logic hw_clk,
    output logic hw_sync,
    output logic hw_up_data,
    input wire logic hw_down_data,
    input wire logic [63:0] up_word,
    output logic [63:0] down_word,
    output logic [15:0] frame_no
);
    logic [63:0] acc;
    logic [63:0] cur;
    int idx;
    initial
    begin
        hw_sync = 1'b0;
        hw_up_data = 1'b1;
        down_word = '1;
        frame_no = 16'h0;
        acc = '1;
        cur = '1;
        idx = 63;
        hw_clk = 1'b0;
        forever #32 hw_clk = ~hw_clk;
    end
    // bits move on the falling edge so they are settled at the sampling rise
    always @(negedge hw_clk)
    begin
        acc[idx] = hw_down_data;
        if (idx == 63)
        begin
            down_word = acc;
            frame_no = frame_no + 16'h1;
            cur = up_word;
            idx = 0;
        end
        else
            idx = idx + 1;
        hw_sync = (idx == 0);
        hw_up_data = cur[idx];
    end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the s/q channel, monitor timeout and c/i channel block
// assumes the highway model runs free; an upstream word change lands one frame late
`timescale 1ns/1ps
module tb_top;
    logic clk, sys_rst, hw_clk, hw_sync, hw_up_data, hw_down_data;
    logic s_active, s_mf_pulse, s_frame_pulse, s_rx_valid, reg_wr, reg_rd;
    logic [3:0] s_rx_s1q, s_rx_s2, s_tx_s1q, s_tx_s2, ci0;
    logic [5:0] ci1;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic [63:0] up_w, dn_w;
    logic [15:0] frame_no;
    int bad_count, checks, n, i;
    // {write, addr, wdata, expected read}
    localparam logic [19:0] ROWS [14] = '{20'h0_00_00, 20'h2_00_0f, 20'h4_00_3f,
        20'h1_00_0f, 20'h3_00_3f, 20'h9_05_00, 20'h1_00_05, 20'hb_2a_00, 20'h3_00_2a,
        20'ha_00_00, 20'h2_00_0f, 20'hf_ff_00, 20'h7_00_00, 20'h5_00_00};
    sqci_top i_dut (
        .clk(clk), .sys_rst(sys_rst), .hw_clk(hw_clk), .hw_sync(hw_sync),
        .hw_up_data(hw_up_data), .hw_down_data(hw_down_data), .s_active(s_active),
        .s_mf_pulse(s_mf_pulse), .s_frame_pulse(s_frame_pulse), .s_rx_valid(s_rx_valid),
        .s_rx_s1q(s_rx_s1q), .s_rx_s2(s_rx_s2), .s_tx_s1q(s_tx_s1q), .s_tx_s2(s_tx_s2),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata)
    );
    sqci_hw_model i_hw (
        .hw_clk(hw_clk), .hw_sync(hw_sync), .hw_up_data(hw_up_data),
        .hw_down_data(hw_down_data), .up_word(up_w), .down_word(dn_w), .frame_no(frame_no)
    );
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask
    task end_of_test;
        $display("checks %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task frames(input int cnt);
        logic [15:0] old;
        int k;
        repeat (cnt)
        begin
            old = frame_no;
            k = 0;
            while (frame_no == old && k < 2000)
            begin
                @(posedge clk);
                k++;
            end
            if (k >= 2000)
            begin
                chk(8'h00, 8'h01);
                end_of_test;
            end
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [2:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // type nibble then data, msb first from bit 16; unused bits idle high
    task up(input logic [7:0] m, input logic mr, input logic mx);
        logic [63:0] w;
        w = '1;
        for (int k = 0; k < 8; k++)
            w[16 + k] = m[7 - k];
        w[29:26] = ci0;
        w[30] = mr;
        w[31] = mx;
        w[61:56] = ci1;
        @(posedge clk);
        up_w <= w;
    endtask
    function automatic logic [7:0] mon(input logic [63:0] w);
        logic [7:0] m;
        for (int k = 0; k < 8; k++)
            m[7 - k] = w[16 + k];
        return m;
    endfunction
    task sframes(input logic with_mf, input int cnt);
        if (with_mf)
        begin
            @(posedge clk);
            s_mf_pulse <= 1'b1;
            @(posedge clk);
            s_mf_pulse <= 1'b0;
        end
        repeat (cnt)
        begin
            @(posedge clk);
            s_frame_pulse <= 1'b1;
            @(posedge clk);
            s_frame_pulse <= 1'b0;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    task rx(input logic [3:0] a, input logic [3:0] b);
        @(posedge clk);
        s_rx_valid <= 1'b1;
        s_rx_s1q <= a;
        s_rx_s2 <= b;
        @(posedge clk);
        s_rx_valid <= 1'b0;
    endtask
    // two idle frames afterwards so a stale acknowledge never counts for the next byte
    task cmd(input logic [7:0] b, input logic exp_ack);
        logic ack;
        ack = 1'b0;
        up(b, 1'b1, 1'b0);
        for (int k = 0; k < 5 && !ack; k++)
        begin
            frames(1);
            ack = !dn_w[30];
        end
        up(8'hff, 1'b1, 1'b1);
        frames(2);
        chk({7'h0, ack}, {7'h0, exp_ack}); // acknowledge as expected
    endtask
    task msg(input logic [7:0] exp, input logic ack);
        int k;
        k = 0;
        while (dn_w[31] && k < 8)
        begin
            frames(1);
            k++;
        end
        chk(mon(dn_w), exp); // byte offered
        if (ack)
        begin
            up(8'hff, 1'b0, 1'b1);
            frames(1);
            up(8'hff, 1'b1, 1'b1);
            frames(2);
        end
    endtask
    initial
    begin
        bad_count = 0;
        checks = 0;
        ci0 = 4'hf;
        ci1 = 6'h3f;
        up_w = '1;
        {sys_rst, s_active, s_mf_pulse, s_frame_pulse, s_rx_valid, reg_wr, reg_rd} = 7'h40;
        {s_rx_s1q, s_rx_s2, reg_addr, reg_wdata} = 19'h0;
        repeat (3) @(posedge clk);
        chk({7'h0, hw_down_data}, 8'h01); // idle high in reset
        chk({s_tx_s1q, s_tx_s2}, 8'h00); // nothing to send yet
        chk(reg_rdata, 8'h00); // read data quiet
        sys_rst <= 1'b0;
        for (i = 0; i < 14; i++)
        begin
            if (ROWS[i][19])
                wr(ROWS[i][18:16], ROWS[i][15:8]);
            else
            begin
                rd(ROWS[i][18:16]);
                chk(rv, ROWS[i][7:0]); // register values
            end
        end
        $display("done: register table");
        frames(2);
        chk({4'h0, dn_w[29:26]}, 8'h05); // code sent each frame
        chk({2'h0, dn_w[61:56]}, 8'h2a); // peripheral code sent
        ci0 = 4'h6;
        ci1 = 6'h2a;
        up(8'hff, 1'b1, 1'b1);
        frames(1);
        ci0 = 4'hf;
        ci1 = 6'h3f;
        up(8'hff, 1'b1, 1'b1);
        frames(3);
        rd(3'h2);
        chk(rv, 8'h0f); // one-frame glitch ignored
        rd(3'h5);
        chk(rv & 8'h03, 8'h02); // only peripheral change flagged
        ci0 = 4'h6;
        up(8'hff, 1'b1, 1'b1);
        frames(4);
        rd(3'h2);
        chk(rv, 8'h06); // steady code taken
        rd(3'h5);
        chk(rv & 8'h01, 8'h01); // change flagged
        $display("done: c/i channels");
        cmd(8'h1a, 1'b0); // inactive interface refuses
        @(posedge clk) s_active <= 1'b1;
        sframes(1'b1, 0);
        cmd(8'h1a, 1'b1); // first command taken
        cmd(8'h1b, 1'b0); // loaded channel refuses
        cmd(8'h25, 1'b0); // second channel ignored
        sframes(1'b0, 17);
        cmd(8'h1c, 1'b1); // late window overwrites
        sframes(1'b1, 0);
        chk({4'h0, s_tx_s1q}, 8'h0c); // latest value sent
        chk({4'h0, s_tx_s2}, 8'h00); // other channel untouched
        wr(3'h0, 8'h04);
        cmd(8'h25, 1'b1); // one command per channel
        wr(3'h0, 8'h06);
        sframes(1'b1, 0);
        chk({4'h0, s_tx_s2}, 8'h00); // pulses ignored
        wr(3'h0, 8'h04);
        sframes(1'b1, 0);
        chk({4'h0, s_tx_s2}, 8'h05); // second register sent
        $display("done: commands");
        rx(4'h3, 4'h9);
        msg(8'h13, 1'b1); // first channel first
        msg(8'h29, 1'b1); // then second channel
        wr(3'h0, 8'h00);
        rx(4'h6, 4'h0);
        msg(8'h16, 1'b1); // changed data reported
        rx(4'h6, 4'h0);
        for (i = 0; i < 4; i++)
        begin
            frames(1);
            chk({7'h0, dn_w[31]}, 8'h01); // unchanged data stays quiet
        end
        $display("done: messages");
        wr(3'h0, 8'h01);
        rx(4'h7, 4'h0);
        msg(8'h17, 1'b0); // held unread
        sframes(1'b1, 20);
        sframes(1'b1, 20);
        rd(3'h5);
        chk(rv & 8'h04, 8'h00); // timeout skipped
        wr(3'h0, 8'h00);
        sframes(1'b1, 20);
        sframes(1'b1, 20);
        rd(3'h5);
        chk(rv & 8'h04, 8'h04); // lock-up seen
        n = 0;
        for (i = 0; i < 8; i++)
        begin
            frames(1);
            if (dn_w[31])
                n++;
            else if (n > 0)
                break;
        end
        chk(n[7:0], 8'h02); // two frames end of message
        chk(mon(dn_w), 8'h17); // same byte resent
        $display("done: timeout");
        end_of_test;
    end
endmodule
